// [inc/mhs_regs.vh]
// Offsets, field positions, reset values and timing figures of the host sync link
`ifndef MHS_REGS_VH
`define MHS_REGS_VH

// APB byte offsets
`define MHS_APB_STATUS 8'h00
`define MHS_APB_MASK 8'h04
`define MHS_APB_SETUP 8'h08
`define MHS_APB_CTRL 8'h0C
`define MHS_APB_EVENT 8'h10
`define MHS_APB_LINK 8'h14
`define MHS_APB_MEM_SEL 2'h1

// Register indices seen by the UART host
`define MHS_IX_ENERGY_LAST 7'h08
`define MHS_IX_TEMP 7'h13
`define MHS_IX_STATUS 7'h14
`define MHS_IX_MASK 7'h15
`define MHS_IX_SETUP 7'h16
`define MHS_IX_COIL_A 7'h44
`define MHS_IX_COIL_C 7'h46

// Word memory slots
`define MHS_SLOT_TEMP 4'h9
`define MHS_SLOT_COIL_OFS 4'h6

// Command byte
`define MHS_CMD_WR_BIT 7

// Status word fields
`define MHS_ST_READY 0
`define MHS_ST_OVF 1
`define MHS_ST_UNINIT 2
`define MHS_ST_SAG 3
`define MHS_ST_CREEP 4
`define MHS_ST_OVERV 5
`define MHS_ST_OVERI 6
`define MHS_ST_GPIO 9
`define MHS_STATUS_MASK 32'h0000027F
`define MHS_STATUS_RST 32'h00000004

// Setup register fields and reset values
`define MHS_SETUP_CE_EN 4
`define MHS_SETUP_IRQ_EN 8
`define MHS_SETUP_RST 32'h00000000
`define MHS_MASK_RST 32'h00000000

// Timing
`define MHS_CLK_KHZ 25000
`define MHS_TIMEOUT_MS 10
`define MHS_PURGE_UP_MS 20
`define MHS_BOOT_UP_MS 370
`define MHS_BAUD_SLOW 9600
`define MHS_BAUD_FAST 38400

// Width in bits of the pending status-read counter
`define MHS_STAT_QW 4

`endif

// [logic/mhs_word_mem.v]
// Small word memory with one write port and two registered read ports
`timescale 1ns/100ps
`default_nettype none

module mhs_word_mem #(
  parameter WIDTH = 32,
  parameter AW = 4
)(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read ports
  input wire [AW-1:0] rd_addr_a,
  output reg [WIDTH-1:0] rd_data_a,
  input wire [AW-1:0] rd_addr_b,
  output reg [WIDTH-1:0] rd_data_b
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Array itself is not reset, so it maps onto plain RAM
  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_a <= {WIDTH{1'b0}};
      rd_data_b <= {WIDTH{1'b0}};
    end
    else
    begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule
`default_nettype wire

// [logic/mhs_host_link.v]
// Host sync link: UART command port, status word, data-ready line and APB view
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "mhs_regs.vh"

module mhs_host_link #(
  parameter [23:0] TIMEOUT_CYC = `MHS_TIMEOUT_MS * `MHS_CLK_KHZ,
  parameter [23:0] PURGE_UP_CYC = `MHS_PURGE_UP_MS * `MHS_CLK_KHZ,
  parameter [23:0] BOOT_UP_CYC = `MHS_BOOT_UP_MS * `MHS_CLK_KHZ,
  parameter [15:0] DIV_SLOW = `MHS_CLK_KHZ * 1000 / `MHS_BAUD_SLOW,
  parameter [15:0] DIV_FAST = `MHS_CLK_KHZ * 1000 / `MHS_BAUD_FAST
)(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Host pins
  input wire uart_rx,
  output reg uart_tx,
  output reg data_ready_irq_n,
  input wire hw_reset_n,
  input wire serial_port_purge_n,
  input wire line_speed_select,
  input wire pulse_polarity_select,
  // Metering side
  output reg pulse_polarity,
  output wire compute_enable
);

  localparam STAT_QW = `MHS_STAT_QW;
  localparam [4:0] SYNC_RST = 5'h07;
  localparam CMD_IDLE = 1'b0;
  localparam CMD_DATA = 1'b1;
  localparam [1:0] RX_IDLE = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_DATA = 2'h2;
  localparam [1:0] RX_STOP = 2'h3;
  localparam [1:0] TX_IDLE = 2'h0;
  localparam [1:0] TX_PICK = 2'h1;
  localparam [1:0] TX_LOAD = 2'h2;
  localparam [1:0] TX_SHIFT = 2'h3;

  // Maps a host index to {valid, memory slot}
  function [4:0] uart_slot;
    input [6:0] a;
    begin
      if (a <= `MHS_IX_ENERGY_LAST)
        uart_slot = {1'b1, a[3:0]};
      else if (a == `MHS_IX_TEMP)
        uart_slot = {1'b1, `MHS_SLOT_TEMP};
      else if (a >= `MHS_IX_COIL_A && a <= `MHS_IX_COIL_C)
        uart_slot = {1'b1, a[3:0] + `MHS_SLOT_COIL_OFS};
      else
        uart_slot = 5'h00;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [4:0] pin_raw;
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  assign pin_raw = {pulse_polarity_select, line_speed_select, serial_port_purge_n,
                    hw_reset_n, uart_rx};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_a[gi] <= SYNC_RST[gi];
          sync_b[gi] <= SYNC_RST[gi];
        end
        else
        begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire rx_in = sync_b[0];
  wire hw_clr = ~sync_b[1];
  wire purge = ~sync_b[2];
  wire link_clr = hw_clr | purge;

  // ----------------------------------------------------------------
  // Start-up delay and straps
  // ----------------------------------------------------------------
  reg uart_up;
  reg up_from_purge;
  reg [23:0] up_cnt;
  reg line_fast;
  wire [23:0] up_lim = up_from_purge ? PURGE_UP_CYC : BOOT_UP_CYC;
  wire [15:0] bit_div = line_fast ? DIV_FAST : DIV_SLOW;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      uart_up <= 1'b0;
      up_from_purge <= 1'b0;
      up_cnt <= 24'h000000;
    end
    else if (hw_clr)
    begin
      uart_up <= 1'b0;
      up_from_purge <= 1'b0;
      up_cnt <= 24'h000000;
    end
    else if (purge)
    begin
      uart_up <= 1'b0;
      up_from_purge <= 1'b1;
      up_cnt <= 24'h000000;
    end
    else if (!uart_up)
    begin
      if (up_cnt == up_lim - 24'h000001)
        uart_up <= 1'b1;
      up_cnt <= up_cnt + 24'h000001;
    end
  end

  // Straps keep following the pins until the UART is up, so a purge re-reads them
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_fast <= 1'b0;
      pulse_polarity <= 1'b0;
    end
    else if (!uart_up)
    begin
      line_fast <= sync_b[3];
      pulse_polarity <= sync_b[4];
    end
  end

  // ----------------------------------------------------------------
  // UART receiver, 8N1
  // ----------------------------------------------------------------
  reg [1:0] rx_st;
  reg [15:0] rx_div;
  reg [2:0] rx_bit;
  reg [7:0] rx_byte;
  reg rx_done;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st <= RX_IDLE;
      rx_div <= 16'h0000;
      rx_bit <= 3'h0;
      rx_byte <= 8'h00;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (link_clr || !uart_up)
        rx_st <= RX_IDLE;
      else
        case (rx_st)
          RX_IDLE:
            if (!rx_in)
            begin
              rx_st <= RX_START;
              rx_div <= {1'b0, bit_div[15:1]};
            end
          RX_START:
            if (rx_div != 16'h0000)
              rx_div <= rx_div - 16'h0001;
            else if (!rx_in)
            begin
              rx_st <= RX_DATA;
              rx_div <= bit_div - 16'h0001;
              rx_bit <= 3'h0;
            end
            else
              rx_st <= RX_IDLE;
          RX_DATA:
            if (rx_div != 16'h0000)
              rx_div <= rx_div - 16'h0001;
            else
            begin
              rx_byte <= {rx_in, rx_byte[7:1]};
              rx_div <= bit_div - 16'h0001;
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == 3'h7)
                rx_st <= RX_STOP;
            end
          RX_STOP:
            if (rx_div != 16'h0000)
              rx_div <= rx_div - 16'h0001;
            else
            begin
              rx_st <= RX_IDLE;
              // Framing error drops the byte silently
              rx_done <= rx_in;
            end
          default:
            rx_st <= RX_IDLE;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Command parser
  // ----------------------------------------------------------------
  reg cmd_st;
  reg [6:0] cmd_addr;
  reg [31:0] cmd_data;
  reg [1:0] cmd_cnt;
  reg [23:0] idle_cnt;
  reg wr_done;
  reg tout;
  reg [STAT_QW-1:0] stat_pend;
  reg other_pend;
  reg [6:0] other_addr;
  reg [1:0] tx_st;
  reg post_busy;
  wire take_other = (tx_st == TX_IDLE) && other_pend && uart_up;
  wire take_stat = (tx_st == TX_IDLE) && !other_pend && (stat_pend != {STAT_QW{1'b0}}) &&
                   !post_busy && uart_up;
  wire stat_inc = rx_done && (cmd_st == CMD_IDLE) && !rx_byte[`MHS_CMD_WR_BIT] &&
                  (rx_byte[6:0] == `MHS_IX_STATUS) && (stat_pend != {STAT_QW{1'b1}});

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_st <= CMD_IDLE;
      cmd_addr <= 7'h00;
      cmd_data <= 32'h00000000;
      cmd_cnt <= 2'h0;
      idle_cnt <= 24'h000000;
      wr_done <= 1'b0;
      tout <= 1'b0;
      stat_pend <= {STAT_QW{1'b0}};
      other_pend <= 1'b0;
      other_addr <= 7'h00;
    end
    else
    begin
      wr_done <= 1'b0;
      tout <= 1'b0;
      if (link_clr)
      begin
        cmd_st <= CMD_IDLE;
        stat_pend <= {STAT_QW{1'b0}};
        other_pend <= 1'b0;
      end
      else
      begin
        if (take_other)
          other_pend <= 1'b0;
        stat_pend <= stat_pend + {{(STAT_QW-1){1'b0}}, stat_inc} -
                     {{(STAT_QW-1){1'b0}}, take_stat};
        case (cmd_st)
          CMD_IDLE:
            if (rx_done)
            begin
              cmd_addr <= rx_byte[6:0];
              cmd_cnt <= 2'h0;
              idle_cnt <= 24'h000000;
              if (rx_byte[`MHS_CMD_WR_BIT])
                cmd_st <= CMD_DATA;
              else if (rx_byte[6:0] != `MHS_IX_STATUS)
              begin
                other_pend <= 1'b1;
                other_addr <= rx_byte[6:0];
              end
            end
          CMD_DATA:
            if (rx_done)
            begin
              cmd_data <= {cmd_data[23:0], rx_byte};
              idle_cnt <= 24'h000000;
              cmd_cnt <= cmd_cnt + 2'h1;
              if (cmd_cnt == 2'h3)
              begin
                cmd_st <= CMD_IDLE;
                wr_done <= 1'b1;
              end
            end
            else if (idle_cnt == TIMEOUT_CYC - 24'h000001)
            begin
              cmd_st <= CMD_IDLE;
              tout <= 1'b1;
            end
            else
              idle_cnt <= idle_cnt + 24'h000001;
          default:
            cmd_st <= CMD_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word, setup, mask and data-ready line
  // ----------------------------------------------------------------
  reg [31:0] status;
  reg [31:0] next_status;
  reg [31:0] irq_mask;
  reg [31:0] setup;
  reg irq_armed;
  reg tx_is_stat;
  reg [6:0] tx_addr;
  wire apb_wr = psel && penable && pready && pwrite;
  wire apb_aligned = (paddr[1:0] == 2'h0);
  wire apb_mem = apb_aligned && (paddr[7:6] == `MHS_APB_MEM_SEL);
  wire apb_wr_event = apb_wr && (paddr == `MHS_APB_EVENT);
  wire fresh_evt = apb_wr_event && pwdata[`MHS_ST_READY];
  wire energy_read = (tx_st == TX_PICK) && !tx_is_stat && (tx_addr <= `MHS_IX_ENERGY_LAST);
  assign compute_enable = setup[`MHS_SETUP_CE_EN];

  // Clears first, sets last: an event in the clearing cycle survives
  always @*
  begin
    next_status = status;
    if (apb_wr && (paddr == `MHS_APB_STATUS))
      next_status = next_status & ~pwdata;
    if (wr_done && (cmd_addr == `MHS_IX_STATUS))
      next_status = next_status & ~cmd_data;
    if (energy_read)
      next_status[`MHS_ST_READY] = 1'b0;
    if (apb_wr_event)
      next_status = next_status | pwdata;
    if (tout)
      next_status[`MHS_ST_UNINIT] = 1'b1;
    next_status = next_status & `MHS_STATUS_MASK;
  end

  // Purge leaves this state alone so metering keeps running
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= `MHS_STATUS_RST;
      irq_mask <= `MHS_MASK_RST;
      setup <= `MHS_SETUP_RST;
      post_busy <= 1'b0;
      data_ready_irq_n <= 1'b1;
      irq_armed <= 1'b0;
    end
    else if (hw_clr)
    begin
      status <= `MHS_STATUS_RST;
      irq_mask <= `MHS_MASK_RST;
      setup <= `MHS_SETUP_RST;
      post_busy <= 1'b0;
      data_ready_irq_n <= 1'b1;
      irq_armed <= 1'b0;
    end
    else
    begin
      status <= next_status;
      if (apb_wr && (paddr == `MHS_APB_MASK))
        irq_mask <= pwdata;
      else if (wr_done && (cmd_addr == `MHS_IX_MASK))
        irq_mask <= cmd_data;
      if (apb_wr && (paddr == `MHS_APB_SETUP))
        setup <= pwdata;
      else if (wr_done && (cmd_addr == `MHS_IX_SETUP))
        setup <= cmd_data;
      if (apb_wr && (paddr == `MHS_APB_CTRL))
        post_busy <= pwdata[0];
      // Fresh data win over a read in the same cycle only if armed, enabled and unmasked; otherwise the read wins and releases the line
      if (fresh_evt && irq_armed && setup[`MHS_SETUP_IRQ_EN] &&
          irq_mask[`MHS_ST_READY])
      begin
        data_ready_irq_n <= 1'b0;
        irq_armed <= 1'b0;
      end
      else if (energy_read)
      begin
        data_ready_irq_n <= 1'b1;
        irq_armed <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Word memory: energy snapshots, nominal temperature, coil feeds
  // ----------------------------------------------------------------
  reg uw_pend;
  reg [3:0] uw_slot;
  reg [31:0] uw_data;
  wire [31:0] rd_data_a;
  wire [31:0] rd_data_b;
  wire [4:0] wr_slot = uart_slot(cmd_addr);
  wire [4:0] other_slot = uart_slot(other_addr);
  wire apb_wr_mem = apb_wr && apb_mem;
  wire uw_ok = wr_done && wr_slot[4] && (cmd_addr > `MHS_IX_ENERGY_LAST);

  // Host writes yield to APB writes and retry the next free cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      uw_pend <= 1'b0;
      uw_slot <= 4'h0;
      uw_data <= 32'h00000000;
    end
    else if (uw_ok)
    begin
      uw_pend <= 1'b1;
      uw_slot <= wr_slot[3:0];
      uw_data <= cmd_data;
    end
    else if (!apb_wr_mem)
      uw_pend <= 1'b0;
  end

  mhs_word_mem #(
    .WIDTH(32),
    .AW(4)
  ) u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(apb_wr_mem | uw_pend),
    .wr_addr(apb_wr_mem ? paddr[5:2] : uw_slot),
    .wr_data(apb_wr_mem ? pwdata : uw_data),
    .rd_addr_a(paddr[5:2]),
    .rd_data_a(rd_data_a),
    .rd_addr_b(other_slot[3:0]),
    .rd_data_b(rd_data_b)
  );

  // ----------------------------------------------------------------
  // Response transmitter: four bytes, most significant first
  // ----------------------------------------------------------------
  reg tx_slot_ok;
  reg [31:0] tx_word;
  reg [31:0] word_sel;
  reg [8:0] tx_shift;
  reg [3:0] tx_cnt;
  reg [15:0] tx_div;
  reg [1:0] tx_left;

  always @*
  begin
    if (tx_is_stat)
      word_sel = status;
    else if (tx_addr == `MHS_IX_MASK)
      word_sel = irq_mask;
    else if (tx_addr == `MHS_IX_SETUP)
      word_sel = setup;
    else if (tx_slot_ok)
      word_sel = rd_data_b;
    else
      word_sel = 32'h00000000;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st <= TX_IDLE;
      uart_tx <= 1'b1;
      tx_is_stat <= 1'b0;
      tx_addr <= 7'h00;
      tx_slot_ok <= 1'b0;
      tx_word <= 32'h00000000;
      tx_shift <= 9'h000;
      tx_cnt <= 4'h0;
      tx_div <= 16'h0000;
      tx_left <= 2'h0;
    end
    else if (link_clr)
    begin
      tx_st <= TX_IDLE;
      uart_tx <= 1'b1;
    end
    else
      case (tx_st)
        TX_IDLE:
          if (take_other)
          begin
            tx_is_stat <= 1'b0;
            tx_addr <= other_addr;
            tx_slot_ok <= other_slot[4];
            tx_st <= TX_PICK;
          end
          else if (take_stat)
          begin
            tx_is_stat <= 1'b1;
            tx_st <= TX_PICK;
          end
        TX_PICK:
        begin
          tx_word <= word_sel;
          tx_left <= 2'h3;
          tx_st <= TX_LOAD;
        end
        TX_LOAD:
        begin
          uart_tx <= 1'b0;
          tx_shift <= {1'b1, tx_word[31:24]};
          tx_word <= {tx_word[23:0], 8'h00};
          tx_cnt <= 4'h9;
          tx_div <= bit_div - 16'h0001;
          tx_st <= TX_SHIFT;
        end
        TX_SHIFT:
          if (tx_div != 16'h0000)
            tx_div <= tx_div - 16'h0001;
          else if (tx_cnt == 4'h0)
          begin
            tx_left <= tx_left - 2'h1;
            tx_st <= (tx_left == 2'h0) ? TX_IDLE : TX_LOAD;
          end
          else
          begin
            uart_tx <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[8:1]};
            tx_cnt <= tx_cnt - 4'h1;
            tx_div <= bit_div - 16'h0001;
          end
        default:
          tx_st <= TX_IDLE;
      endcase
  end

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  reg [31:0] apb_rdata;
  reg apb_err;

  always @*
  begin
    apb_rdata = 32'h00000000;
    apb_err = 1'b0;
    if (!apb_aligned)
      apb_err = 1'b1;
    else if (apb_mem)
      apb_rdata = rd_data_a;
    else
      case (paddr)
        `MHS_APB_STATUS: apb_rdata = status;
        `MHS_APB_MASK: apb_rdata = irq_mask;
        `MHS_APB_SETUP: apb_rdata = setup;
        `MHS_APB_CTRL: apb_rdata = {31'h00000000, post_busy};
        `MHS_APB_EVENT: apb_rdata = 32'h00000000;
        `MHS_APB_LINK: apb_rdata = {{(28-STAT_QW){1'b0}}, stat_pend, other_pend, line_fast,
                                    pulse_polarity, uart_up};
        default: apb_err = 1'b1;
      endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : apb_rdata;
      pslverr <= apb_err;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [sim/mhs_host_link_monitor.sv]
// Port checker for the host sync link
`timescale 1ns/100ps
`default_nettype none
`include "mhs_regs.vh"
module mhs_host_link_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Host pins
  input wire logic uart_tx,
  input wire logic data_ready_irq_n,
  input wire logic hw_reset_n,
  input wire logic serial_port_purge_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_pairs: assert property (pslverr |-> pready)
    else $error("lone pslverr");
  a_unmapped_err: assert property (pready && paddr == 8'h18 |-> pslverr)
    else $error("unmapped accepted");
  a_write_rd_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata on write");
  a_irq_fall_cause: assert property ($fell(data_ready_irq_n) |->
    $past(psel && penable && pready && pwrite && paddr == `MHS_APB_EVENT && pwdata[0]))
    else $error("irq without event");
  a_reset_quiet: assert property (!hw_reset_n [*5] |-> data_ready_irq_n && uart_tx)
    else $error("reset not quiet");
  a_purge_tx_idle: assert property (!serial_port_purge_n [*5] |-> uart_tx)
    else $error("tx busy in purge");
endmodule
`default_nettype wire

// [sim/mhs_uart_host.sv]
// Host side UART partner
`timescale 1ns/100ps
`default_nettype none
module mhs_uart_host (
  // Clock
  input wire logic pclk,
  // Serial lines
  output logic tx,
  input wire logic rx
);
  integer div = 16;
  initial tx = 1'b1;
  // Clean 8N1 frames, nothing inserted
  task send(input [7:0] b);
    integer i;
    reg [9:0] f;
    begin
      f = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1)
      begin
        tx <= f[i];
        repeat (div) @(posedge pclk);
      end
    end
  endtask
  // Bytes MSB first, bits LSB first
  task get(output [31:0] w);
    integer i, k;
    reg [7:0] b;
    begin
      w = 32'h0;
      for (k = 0; k < 4; k = k + 1)
      begin
        @(posedge pclk);
        while (rx) @(posedge pclk);
        repeat (div / 2) @(posedge pclk);
        for (i = 0; i < 8; i = i + 1)
        begin
          repeat (div) @(posedge pclk);
          b[i] = rx;
        end
        repeat (div) @(posedge pclk);
        w = {w[23:0], b};
      end
    end
  endtask
endmodule
`default_nettype wire

// [sim/meter_host_sync_link_test.sv]
// Self-checking bench for the host sync link
`timescale 1ns/100ps
`default_nettype none
`include "mhs_regs.vh"
module meter_host_sync_link_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, w;
  logic pready, pslverr, uart_rx, uart_tx, irq_n, ce, pol, err;
  logic hw_n = 1'b1, purge_n = 1'b1, spd = 1'b0, pol_sel = 1'b1;
  integer n_fail = 0, samples_checked = 0, cyc = 0;
  always #20 pclk = ~pclk;
  mhs_host_link #(.TIMEOUT_CYC(24'd200), .PURGE_UP_CYC(24'd100), .BOOT_UP_CYC(24'd300),
    .DIV_SLOW(16'd16), .DIV_FAST(16'd8)) mhs_host_link_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .uart_rx(uart_rx),
    .uart_tx(uart_tx), .data_ready_irq_n(irq_n), .hw_reset_n(hw_n),
    .serial_port_purge_n(purge_n), .line_speed_select(spd),
    .pulse_polarity_select(pol_sel), .pulse_polarity(pol), .compute_enable(ce));
  mhs_uart_host mhs_uart_host_i (.pclk(pclk), .tx(uart_rx), .rx(uart_tx));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rchk(input string nm, input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, r, e);
    end
  endtask
  task wait_up;
    integer t;
    begin
      r = 32'h0;
      for (t = 0; t < 200 && r[0] !== 1'b1; t = t + 1)
        apb(1'b0, `MHS_APB_LINK, 32'h0);
    end
  endtask
  task hrd(input [7:0] i);
    fork
      mhs_uart_host_i.send(i);
      mhs_uart_host_i.get(w);
    join
  endtask
  task hwr(input [7:0] i, input [31:0] d);
    integer k;
    begin
      mhs_uart_host_i.send(8'h80 | i);
      for (k = 3; k >= 0; k = k - 1)
        mhs_uart_host_i.send(d[8*k +: 8]);
    end
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk("status", `MHS_APB_STATUS, `MHS_STATUS_RST);
    rchk("setup", `MHS_APB_SETUP, `MHS_SETUP_RST);
    rchk("link", `MHS_APB_LINK, 32'h2);
    rchk("unmapped", 8'h18, 32'h0);
    chk("slverr", err, 32'h1);
    wait_up;
    chk("up", r & 32'h1, 32'h1);
    apb(1'b1, `MHS_APB_EVENT, 32'hFFFFFFFE);
    rchk("flags", `MHS_APB_STATUS, 32'h27E);
    apb(1'b1, `MHS_APB_STATUS, 32'hFFFFFFFF);
    rchk("w1c", `MHS_APB_STATUS, 32'h0);
    $display("test status done");
    // Arm by one energy read, then event masked and unmasked
    apb(1'b1, `MHS_APB_SETUP, 32'h110);
    apb(1'b1, 8'h40, 32'h0000C0DE);
    apb(1'b1, 8'h60, 32'h00BEEF08);
    hrd(8'h00);
    chk("energy0", w, 32'h0000C0DE);
    chk("ce", ce, 32'h1);
    apb(1'b1, `MHS_APB_EVENT, 32'h1);
    apb(1'b0, `MHS_APB_STATUS, 32'h0);
    chk("masked", irq_n, 32'h1);
    apb(1'b1, `MHS_APB_MASK, 32'h1);
    apb(1'b1, `MHS_APB_EVENT, 32'h1);
    apb(1'b0, `MHS_APB_STATUS, 32'h0);
    chk("irq", irq_n, 32'h0);
    fork
      begin
        mhs_uart_host_i.send(`MHS_IX_STATUS);
        mhs_uart_host_i.send(`MHS_IX_STATUS);
      end
      begin
        mhs_uart_host_i.get(w);
        chk("q1", w, 32'h1);
        mhs_uart_host_i.get(w);
        chk("q2", w, 32'h1);
      end
    join
    chk("held", irq_n, 32'h0);
    hrd(`MHS_IX_ENERGY_LAST);
    chk("energy8", w, 32'h00BEEF08);
    chk("irq off", irq_n, 32'h1);
    apb(1'b1, `MHS_APB_CTRL, 32'h1);
    mhs_uart_host_i.send(`MHS_IX_STATUS);
    repeat (100) @(posedge pclk);
    rchk("pending", `MHS_APB_LINK, 32'h13);
    fork
      mhs_uart_host_i.get(w);
      apb(1'b1, `MHS_APB_CTRL, 32'h0);
    join
    chk("late", w, 32'h0);
    $display("test irq done");
    mhs_uart_host_i.send(8'h80 | `MHS_IX_MASK);
    mhs_uart_host_i.send(8'h12);
    repeat (220) @(posedge pclk);
    rchk("uninit", `MHS_APB_STATUS, 32'h4);
    rchk("kept", `MHS_APB_MASK, 32'h1);
    hwr(`MHS_IX_TEMP, 32'h12345678);
    rchk("temp", 8'h64, 32'h12345678);
    hwr(`MHS_IX_COIL_A, 32'hA5C30F96);
    rchk("coil", 8'h68, 32'hA5C30F96);
    $display("test host done");
    purge_n <= 1'b0;
    spd <= 1'b1;
    pol_sel <= 1'b0;
    repeat (10) @(posedge pclk);
    rchk("purged", `MHS_APB_LINK, 32'h4);
    chk("pol", pol, 32'h0);
    rchk("mask", `MHS_APB_MASK, 32'h1);
    purge_n <= 1'b1;
    wait_up;
    chk("back", r & 32'h1, 32'h1);
    mhs_uart_host_i.div = 8;
    hrd(`MHS_IX_STATUS);
    chk("fast", w, 32'h4);
    $display("test purge done");
    hw_n <= 1'b0;
    repeat (6) @(posedge pclk);
    hw_n <= 1'b1;
    repeat (3) @(posedge pclk);
    rchk("hw status", `MHS_APB_STATUS, `MHS_STATUS_RST);
    rchk("hw mask", `MHS_APB_MASK, `MHS_MASK_RST);
    chk("hw ce", ce, 32'h0);
    $display("test reset pin done");
    tally_and_finish;
  end
endmodule
bind mhs_host_link mhs_host_link_monitor mhs_host_link_monitor_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .uart_tx(uart_tx),
  .data_ready_irq_n(data_ready_irq_n), .hw_reset_n(hw_reset_n),
  .serial_port_purge_n(serial_port_purge_n));
`default_nettype wire
